// *** include/fps_pkg.sv ***
// constants and types for the flash page program sequencer
package fps_pkg;
   // ======================================================
   // geometry
   localparam int WORDS = 64;
   localparam int WIDX_W = 6;
   localparam int PAGE_W = 10;
   localparam int ADDR_W = 16;
   localparam int REGION_W = 4;
   localparam int FUSE_W = 32;
   // ======================================================
   // command register layout
   localparam int KEY_LO = 24;
   localparam int PAGE_NUMBER_FIELD_LO = 8;
   localparam int CMD_W = 6;
   localparam logic [7:0] CMD_KEY = 8'hA5; // value arbitrary
   localparam logic [5:0] CMD_WP = 6'h01;
   localparam logic [5:0] CMD_EP = 6'h02;
   localparam logic [5:0] CMD_CPB = 6'h03;
   localparam logic [5:0] CMD_LP = 6'h04;
   localparam logic [5:0] CMD_UP = 6'h05;
   localparam logic [5:0] CMD_EA = 6'h06;
   localparam logic [5:0] CMD_WGPB = 6'h07;
   localparam logic [5:0] CMD_EGPB = 6'h08;
   localparam logic [5:0] CMD_QPR = 6'h0C;
   localparam logic [5:0] CMD_WUP = 6'h0D;
   localparam logic [5:0] CMD_EUP = 6'h0E;
   localparam logic [5:0] CMD_SSB = 6'h0F;
   // ======================================================
   // fuses, timing, reset values
   localparam int BOOTP_LO = 17;
   localparam int PROT_LO = 16;
   localparam logic [2:0] BOOTP_NONE = 3'h7;
   localparam logic [2:0] BUF_WAIT = 3'h4;
   localparam logic [31:0] FUSE_RST = 32'hFFFFFFFF;
   localparam logic [31:0] BUF_RST = 32'hFFFFFFFF;

   typedef enum logic [1:0] {NVM_NOP, NVM_PROG, NVM_ERASE_PAGE, NVM_ERASE_ALL} fps_nvm_op_e;

   typedef struct packed {
      logic write;
      logic word_size;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } fps_sb_req_s;

   typedef struct packed {
      fps_nvm_op_e op;
      logic user;
      logic [PAGE_W-1:0] page;
      logic [WIDX_W-1:0] word;
      logic [31:0] wdata;
   } fps_nvm_cmd_s;
endpackage

// *** sim/fps_flash_model.sv ***
// behavioural flash array and volatile-memory clear responder
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
   input wire logic ref_clk,
   input wire fps_pkg::fps_nvm_cmd_s nvm_cmd,
   input wire logic [fps_pkg::ADDR_W-1:0] nvm_rd_addr,
   output logic [31:0] nvm_rdata,
   input wire logic vol_clear_req,
   output logic vol_clear_done,
   input wire logic [7:0] clear_delay
);
   logic [31:0] mem [0:65535];
   logic [31:0] user_mem [0:63];
   logic cleared = 1'b0;
   logic early_erase = 1'b0;
   int wait_cnt = 0;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 32'hFFFFFFFF;
      end
      for (int i = 0; i < 64; i++) begin
         user_mem[i] = 32'hFFFFFFFF;
      end
   end

   // read port answers in the same cycle, as the controller expects
   assign nvm_rdata = mem[nvm_rd_addr];

   // ======================================================
   // array updates; programming can only clear bits, like real cells
   always @(posedge ref_clk) begin
      vol_clear_done <= 1'b0;
      if (vol_clear_req && !vol_clear_done) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= int'(clear_delay)) begin
            vol_clear_done <= 1'b1;
            wait_cnt <= 0;
            cleared <= 1'b1;
         end
      end
      case (nvm_cmd.op)
         fps_pkg::NVM_PROG: begin
            if (nvm_cmd.user) begin
               user_mem[nvm_cmd.word] <= user_mem[nvm_cmd.word] & nvm_cmd.wdata;
            end else begin
               mem[{nvm_cmd.page, nvm_cmd.word}] <= mem[{nvm_cmd.page, nvm_cmd.word}]
                  & nvm_cmd.wdata;
            end
         end
         fps_pkg::NVM_ERASE_PAGE: begin
            for (int w = 0; w < 64; w++) begin
               if (nvm_cmd.user) begin
                  user_mem[w] <= 32'hFFFFFFFF;
               end else begin
                  mem[{nvm_cmd.page, w[5:0]}] <= 32'hFFFFFFFF;
               end
            end
         end
         fps_pkg::NVM_ERASE_ALL: begin
            // erasing before the volatile clear finished would leak secrets
            if (!cleared) begin
               early_erase <= 1'b1;
            end
            cleared <= 1'b0;
            for (int i = 0; i < 65536; i++) begin
               mem[i] <= 32'hFFFFFFFF;
            end
         end
         default: begin
         end
      endcase
   end
endmodule
`default_nettype wire

// *** sim/tb_flash_page_program_sequencer.sv ***
// self-checking bench for the flash page program sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_flash_page_program_sequencer;
   logic ref_clk, rst_n, sb_req, sb_ready, cmd_wr, cmd_secure, status_rd, ready_int_en;
   logic lock_err_int_en, ready_flag, programming_error_flag, lock_error_flag, irq;
   logic quick_page_check_result, security_set, vol_clear_req, vol_clear_done;
   fps_pkg::fps_sb_req_s sb_bus;
   fps_pkg::fps_nvm_cmd_s nvm_cmd;
   logic [31:0] sb_rdata, cmd_wdata, nvm_rdata, fuse_bits, lfsr, a, q;
   logic [9:0] secure_page_count, page_number_field;
   logic [15:0] nvm_rd_addr;
   logic [7:0] clear_delay;
   logic [31:0] exp_w [0:63];
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   int overlap = 0;

   fps_nvm_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .sb_req(sb_req), .sb_bus(sb_bus),
      .sb_ready(sb_ready), .sb_rdata(sb_rdata), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
      .cmd_secure(cmd_secure), .status_rd(status_rd), .ready_int_en(ready_int_en),
      .lock_err_int_en(lock_err_int_en), .secure_page_count(secure_page_count),
      .ready_flag(ready_flag), .programming_error_flag(programming_error_flag),
      .lock_error_flag(lock_error_flag), .quick_page_check_result(quick_page_check_result),
      .irq(irq), .page_number_field(page_number_field), .fuse_bits(fuse_bits),
      .security_set(security_set), .vol_clear_req(vol_clear_req),
      .vol_clear_done(vol_clear_done), .nvm_cmd(nvm_cmd), .nvm_rd_addr(nvm_rd_addr),
      .nvm_rdata(nvm_rdata));
   fps_flash_model partner_u (.ref_clk(ref_clk), .nvm_cmd(nvm_cmd), .nvm_rd_addr(nvm_rd_addr),
      .nvm_rdata(nvm_rdata), .vol_clear_req(vol_clear_req), .vol_clear_done(vol_clear_done),
      .clear_delay(clear_delay));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ======================================================
   // watchdog and command-versus-write overlap monitor
   always @(posedge ref_clk) begin
      cycles++;
      if (rst_n && sb_req && sb_bus.write && nvm_cmd.op != fps_pkg::NVM_NOP) begin
         overlap++;
      end
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic rnd(output logic [31:0] v);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      v = lfsr;
   endtask

   // ======================================================
   // bus, command and status helpers
   task automatic sb_xfer(input logic wr, input logic [15:0] ad, input logic [31:0] d,
                          output logic [31:0] r);
      int waits;
      waits = 0;
      @(posedge ref_clk);
      sb_req <= 1'b1;
      sb_bus <= fps_pkg::fps_sb_req_s'{write: wr, word_size: 1'b1, addr: ad, wdata: d};
      @(posedge ref_clk);
      while (sb_ready !== 1'b1 && waits < 3000) begin
         waits++;
         @(posedge ref_clk);
      end
      r = sb_rdata;
      if (!wr) `CHK(ready_flag, 1'b1)
      if (wr) `CHK(waits, 4)
      sb_req <= 1'b0;
   endtask

   task automatic cmd(input logic [5:0] code, input logic [9:0] pg, input logic [7:0] key,
                      input logic sec, input logic wait_done);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd_wr <= 1'b1;
      cmd_secure <= sec;
      cmd_wdata <= {key, 6'h00, pg, 2'h0, code};
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
      @(posedge ref_clk);
      `CHK(ready_flag, 1'b0)
      while (wait_done && ready_flag !== 1'b1 && n < 5000) begin
         n++;
         @(posedge ref_clk);
      end
      if (wait_done) `CHK(ready_flag, 1'b1)
   endtask

   task automatic status(input logic pe, input logic le);
      @(posedge ref_clk);
      `CHK(programming_error_flag, pe)
      `CHK(lock_error_flag, le)
      status_rd <= 1'b1;
      @(posedge ref_clk);
      status_rd <= 1'b0;
      @(posedge ref_clk);
      `CHK({programming_error_flag, lock_error_flag}, 2'b00)
   endtask

   task automatic load(input logic [9:0] p);
      logic [31:0] x, y, r;
      for (int i = 0; i < 63; i++) begin
         rnd(x);
         rnd(y);
         sb_xfer(1'b1, {p, i[5:0]}, x, r);
         sb_xfer(1'b1, {p, i[5:0]}, y, r);
         exp_w[i] = x & y;
      end
      `CHK(page_number_field, p)
   endtask

   task automatic check_page(input logic [9:0] p, input logic ones);
      logic [31:0] r;
      for (int i = 0; i < 64; i++) begin
         sb_xfer(1'b0, {p, i[5:0]}, 32'h00000000, r);
         `CHK(r, ones ? 32'hFFFFFFFF : exp_w[i])
      end
   endtask

   // ======================================================
   // main sequence
   initial begin
      rst_n = 1'b0; sb_req = 1'b0; sb_bus = '0; cmd_wr = 1'b0; cmd_wdata = '0;
      cmd_secure = 1'b1; status_rd = 1'b0; ready_int_en = 1'b1; lock_err_int_en = 1'b1;
      secure_page_count = 10'h004; clear_delay = 8'h03; lfsr = 32'h7655;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      `CHK({ready_flag, programming_error_flag, lock_error_flag}, 3'b100)
      `CHK(page_number_field, 10'h000)
      load(10'h123); // no clear first: the buffer starts at all ones
      exp_w[63] = 32'hFFFFFFFF;
      rnd(a);
      exp_w[63] = a;
      // page write issued while the last buffer write is still in flight
      fork
         sb_xfer(1'b1, {10'h123, 6'h3F}, a, q);
         begin
            @(posedge ref_clk);
            cmd(fps_pkg::CMD_WP, 10'h123, fps_pkg::CMD_KEY, 1'b1, 1'b1);
         end
      join
      check_page(10'h123, 1'b0);
      `CHK(irq, 1'b1)
      `CHK(overlap, 0)
      cmd(fps_pkg::CMD_WP, 10'h124, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      check_page(10'h124, 1'b0);
      cmd(fps_pkg::CMD_QPR, 10'h124, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK({quick_page_check_result, irq}, 2'b00)
      cmd(fps_pkg::CMD_QPR, 10'h200, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(quick_page_check_result, 1'b1)
      ready_int_en <= 1'b0;
      cmd(fps_pkg::CMD_CPB, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(irq, 1'b0)
      ready_int_en <= 1'b1;
      rnd(a);
      exp_w[5] = exp_w[5] & a;
      sb_xfer(1'b1, {10'h124, 6'h05}, exp_w[5], q);
      cmd(fps_pkg::CMD_WP, 10'h124, fps_pkg::CMD_KEY, 1'b1, 1'b0);
      // read issued while the page write runs: stalls until it is done
      sb_xfer(1'b0, {10'h124, 6'h05}, 32'h00000000, q);
      `CHK(q, exp_w[5])
      check_page(10'h124, 1'b0);
      cmd(fps_pkg::CMD_WP, 10'h300, 8'h5A, 1'b1, 1'b1);
      status(1'b1, 1'b0);
      cmd(6'h3F, 10'h300, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      status(1'b1, 1'b0);
      check_page(10'h300, 1'b1);
      for (int i = 0; i < 64; i++) begin
         if (i != 5) exp_w[i] = 32'hFFFFFFFF;
      end
      cmd(fps_pkg::CMD_WP, 10'h300, fps_pkg::CMD_KEY, 1'b1, 1'b0);
      cmd(fps_pkg::CMD_CPB, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      status(1'b1, 1'b0);
      check_page(10'h300, 1'b0);
      cmd(fps_pkg::CMD_WUP, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(partner_u.user_mem[5], exp_w[5])
      cmd(fps_pkg::CMD_WP, 10'h002, fps_pkg::CMD_KEY, 1'b0, 1'b1);
      status(1'b0, 1'b1);
      check_page(10'h002, 1'b1);
      cmd(fps_pkg::CMD_LP, 10'h2C5, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(fuse_bits[15:0], 16'hF7FF)
      cmd(fps_pkg::CMD_WP, 10'h2C0, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      status(1'b0, 1'b1);
      // ready interrupt off, so only the lock error can raise the line
      ready_int_en <= 1'b0;
      cmd(fps_pkg::CMD_EA, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(irq, 1'b1)
      ready_int_en <= 1'b1;
      status(1'b0, 1'b1);
      sb_xfer(1'b0, {10'h124, 6'h05}, 32'h00000000, q);
      `CHK(q, exp_w[5])
      cmd(fps_pkg::CMD_UP, 10'h2FF, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(fuse_bits[15:0], 16'hFFFF)
      cmd(fps_pkg::CMD_WGPB, 10'h013, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(fuse_bits[19], 1'b0)
      cmd(fps_pkg::CMD_WP, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      status(1'b0, 1'b1);
      cmd(fps_pkg::CMD_EA, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      status(1'b0, 1'b1);
      cmd(fps_pkg::CMD_EGPB, 10'h013, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      cmd(fps_pkg::CMD_SSB, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK(security_set, 1'b1)
      clear_delay <= 8'h14;
      cmd(fps_pkg::CMD_EA, 10'h000, fps_pkg::CMD_KEY, 1'b1, 1'b1);
      `CHK({security_set, partner_u.early_erase}, 2'b00)
      `CHK(fuse_bits, 32'hFFFFFFFF)
      `CHK(partner_u.user_mem[5], exp_w[5])
      sb_xfer(1'b0, {10'h124, 6'h05}, 32'h00000000, q);
      `CHK(q, 32'hFFFFFFFF)
      summarize();
   end
endmodule
`default_nettype wire

// *** verilog/fps_nvm_ctrl.sv ***
// flash page program sequencer: page buffer, command engine, status
`timescale 1ns/1ps
`default_nettype none
module fps_nvm_ctrl (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sb_req,
   input wire fps_pkg::fps_sb_req_s sb_bus,
   output logic sb_ready,
   output logic [31:0] sb_rdata,
   input wire logic cmd_wr,
   input wire logic [31:0] cmd_wdata,
   input wire logic cmd_secure,
   input wire logic status_rd,
   input wire logic ready_int_en,
   input wire logic lock_err_int_en,
   input wire logic [fps_pkg::PAGE_W-1:0] secure_page_count,
   output logic ready_flag,
   output logic programming_error_flag,
   output logic lock_error_flag,
   output logic quick_page_check_result,
   output logic irq,
   output logic [fps_pkg::PAGE_W-1:0] page_number_field,
   output logic [fps_pkg::FUSE_W-1:0] fuse_bits,
   output logic security_set,
   output logic vol_clear_req,
   input wire logic vol_clear_done,
   output fps_pkg::fps_nvm_cmd_s nvm_cmd,
   output logic [fps_pkg::ADDR_W-1:0] nvm_rd_addr,
   input wire logic [31:0] nvm_rdata
);
   typedef enum logic [2:0] {ST_IDLE, ST_PEND, ST_PROG, ST_QCHK, ST_VCLR, ST_DONE} fps_state_e;

   fps_state_e state;
   logic [31:0] pbuf [fps_pkg::WORDS];
   logic [2:0] wcnt;
   logic rd_pend;
   logic [fps_pkg::WIDX_W-1:0] cnt;
   logic [fps_pkg::CMD_W-1:0] cmd;
   logic [7:0] cmd_key;
   logic cmd_sec;
   logic user_sel;
   logic qacc;
   logic irq_ok;
   logic busy;
   logic cmd_acc;
   logic go;
   logic key_ok;
   logic cmd_valid;
   logic prot_hit;
   logic ea_blocked;
   logic fuse_blocked;
   logic clr_buf;
   logic ev_programming_error_flag;
   logic ev_lock_error_flag;
   logic [fps_pkg::REGION_W-1:0] region;
   logic [2:0] bootp;
   logic [fps_pkg::PAGE_W:0] boot_pages;
   logic [4:0] fuse_idx;

   assign busy = (state != ST_IDLE);
   assign cmd_acc = cmd_wr && !busy;
   // bus interface idle: no request and no buffer write or read in flight
   assign go = (state == ST_PEND) && !sb_req && (wcnt == 3'h0) && !rd_pend;
   assign region = page_number_field[fps_pkg::PAGE_W-1 -: fps_pkg::REGION_W];
   assign bootp = fuse_bits[fps_pkg::BOOTP_LO +: 3];
   assign fuse_idx = page_number_field[4:0];
   assign vol_clear_req = (state == ST_VCLR);

   // ======================================================
   // command decode and protection checks
   always_comb begin
      key_ok = (cmd_key == fps_pkg::CMD_KEY);
      case (cmd)
         fps_pkg::CMD_WP, fps_pkg::CMD_EP, fps_pkg::CMD_CPB, fps_pkg::CMD_LP,
         fps_pkg::CMD_UP, fps_pkg::CMD_EA, fps_pkg::CMD_WGPB, fps_pkg::CMD_EGPB,
         fps_pkg::CMD_QPR, fps_pkg::CMD_WUP, fps_pkg::CMD_EUP,
         fps_pkg::CMD_SSB: cmd_valid = 1'b1;
         default: cmd_valid = 1'b0;
      endcase
      // protected pages 0 .. 2**(7-bootp)-1; code 7 protects none
      boot_pages = (bootp == fps_pkg::BOOTP_NONE) ? '0 :
                   (fps_pkg::PAGE_W+1)'(1) << (fps_pkg::BOOTP_NONE - bootp);
      prot_hit = !fuse_bits[region]
              || ({1'b0, page_number_field} < boot_pages)
              || (!cmd_sec && (page_number_field < secure_page_count));
      ea_blocked = !(&fuse_bits[15:0]) || (bootp != fps_pkg::BOOTP_NONE);
      fuse_blocked = security_set && (fuse_idx >= 5'(fps_pkg::PROT_LO));
      clr_buf = go && key_ok && (cmd == fps_pkg::CMD_CPB);
      ev_programming_error_flag = (cmd_wr && busy) || (go && !(key_ok && cmd_valid));
      ev_lock_error_flag = go && key_ok && (
         (((cmd == fps_pkg::CMD_WP) || (cmd == fps_pkg::CMD_EP)) && prot_hit)
         || ((cmd == fps_pkg::CMD_EA) && ea_blocked)
         || (((cmd == fps_pkg::CMD_WGPB) || (cmd == fps_pkg::CMD_EGPB)) && fuse_blocked));
   end

   // ======================================================
   // system bus side: buffer writes with wait states, flash reads
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wcnt <= 3'h0;
         rd_pend <= 1'b0;
         sb_rdata <= 32'h00000000;
         page_number_field <= '0;
      end else begin
         rd_pend <= 1'b0;
         if (wcnt != 3'h0) begin
            wcnt <= wcnt - 3'h1;
         end else if (sb_req && !busy && !rd_pend && sb_bus.write) begin
            wcnt <= fps_pkg::BUF_WAIT;
            page_number_field <= sb_bus.addr[fps_pkg::ADDR_W-1:fps_pkg::WIDX_W];
         end else if (sb_req && !busy && !rd_pend && !sb_bus.write) begin
            rd_pend <= 1'b1;
            sb_rdata <= nvm_rdata;
         end
         // command write beats a buffer write accepted in the same cycle
         if (cmd_acc) begin
            page_number_field <= cmd_wdata[fps_pkg::PAGE_NUMBER_FIELD_LO +: fps_pkg::PAGE_W];
         end
      end
   end

   // stalls until the last wait state, and all reads while a command runs
   assign sb_ready = rd_pend || (wcnt == 3'h1);

   // ======================================================
   // page buffer
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < fps_pkg::WORDS; i++) begin
         if (!rst_n || clr_buf) begin
            pbuf[i] <= fps_pkg::BUF_RST;
         end else if (sb_req && !busy && !rd_pend && (wcnt == 3'h0) && sb_bus.write
                      && sb_bus.word_size
                      && (sb_bus.addr[fps_pkg::WIDX_W-1:0] == fps_pkg::WIDX_W'(i))) begin
            pbuf[i] <= pbuf[i] & sb_bus.wdata;
         end
      end
   end

   // ======================================================
   // command engine, fuses and security bit
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cmd <= '0;
         cmd_key <= 8'h00;
         cmd_sec <= 1'b0;
         user_sel <= 1'b0;
         cnt <= '0;
         qacc <= 1'b1;
         quick_page_check_result <= 1'b0;
         fuse_bits <= fps_pkg::FUSE_RST;
         security_set <= 1'b0;
         nvm_cmd <= '0;
      end else begin
         nvm_cmd.op <= fps_pkg::NVM_NOP;
         case (state)
            ST_IDLE: begin
               if (cmd_acc) begin
                  cmd <= cmd_wdata[fps_pkg::CMD_W-1:0];
                  cmd_key <= cmd_wdata[31:fps_pkg::KEY_LO];
                  cmd_sec <= cmd_secure;
                  state <= ST_PEND;
               end
            end
            ST_PEND: begin
               if (go) begin
                  state <= ST_DONE;
                  cnt <= '0;
                  user_sel <= 1'b0;
                  qacc <= 1'b1;
                  if (key_ok && cmd_valid) begin
                     case (cmd)
                        fps_pkg::CMD_WP: begin
                           if (!prot_hit) begin
                              state <= ST_PROG;
                           end
                        end
                        fps_pkg::CMD_WUP: begin
                           user_sel <= 1'b1;
                           state <= ST_PROG;
                        end
                        fps_pkg::CMD_EP, fps_pkg::CMD_EUP: begin
                           if ((cmd == fps_pkg::CMD_EUP) || !prot_hit) begin
                              nvm_cmd.op <= fps_pkg::NVM_ERASE_PAGE;
                              nvm_cmd.user <= (cmd == fps_pkg::CMD_EUP);
                              nvm_cmd.page <= page_number_field;
                           end
                        end
                        fps_pkg::CMD_LP: fuse_bits[region] <= 1'b0;
                        fps_pkg::CMD_UP: fuse_bits[region] <= 1'b1;
                        fps_pkg::CMD_WGPB: begin
                           if (!fuse_blocked) begin
                              fuse_bits[fuse_idx] <= 1'b0;
                           end
                        end
                        fps_pkg::CMD_EGPB: begin
                           if (!fuse_blocked) begin
                              fuse_bits[fuse_idx] <= 1'b1;
                           end
                        end
                        fps_pkg::CMD_EA: begin
                           if (!ea_blocked) begin
                              state <= ST_VCLR;
                           end
                        end
                        fps_pkg::CMD_QPR: state <= ST_QCHK;
                        fps_pkg::CMD_SSB: security_set <= 1'b1;
                        default: state <= ST_DONE;
                     endcase
                  end
               end
            end
            ST_PROG: begin
               // whole buffer, one word per cycle; buffer is left intact afterwards
               nvm_cmd.op <= fps_pkg::NVM_PROG;
               nvm_cmd.user <= user_sel;
               nvm_cmd.page <= page_number_field;
               nvm_cmd.word <= cnt;
               nvm_cmd.wdata <= pbuf[cnt];
               cnt <= cnt + 1'b1;
               if (cnt == fps_pkg::WIDX_W'(fps_pkg::WORDS - 1)) begin
                  state <= ST_DONE;
               end
            end
            ST_QCHK: begin
               qacc <= qacc & (&nvm_rdata);
               cnt <= cnt + 1'b1;
               if (cnt == fps_pkg::WIDX_W'(fps_pkg::WORDS - 1)) begin
                  quick_page_check_result <= qacc & (&nvm_rdata);
                  state <= ST_DONE;
               end
            end
            ST_VCLR: begin
               // array and fuses only after volatile memories report clean
               if (vol_clear_done) begin
                  nvm_cmd.op <= fps_pkg::NVM_ERASE_ALL;
                  nvm_cmd.user <= 1'b0;
                  fuse_bits <= fps_pkg::FUSE_RST;
                  security_set <= 1'b0;
                  state <= ST_DONE;
               end
            end
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // quick check walks the page through the shared read port
   always_comb begin
      if (state == ST_QCHK) begin
         nvm_rd_addr = {page_number_field, cnt};
      end else begin
         nvm_rd_addr = sb_bus.addr;
      end
   end

   // ======================================================
   // status flags and interrupt line
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ready_flag <= 1'b1;
         programming_error_flag <= 1'b0;
         lock_error_flag <= 1'b0;
         irq_ok <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (cmd_acc) begin
            ready_flag <= 1'b0;
            irq_ok <= 1'b0;
         end else if (state == ST_DONE) begin
            ready_flag <= 1'b1;
            irq_ok <= (cmd != fps_pkg::CMD_QPR);
         end
         // a new error in the reading cycle is kept: set wins
         if (ev_programming_error_flag) begin
            programming_error_flag <= 1'b1;
         end else if (status_rd) begin
            programming_error_flag <= 1'b0;
         end
         if (ev_lock_error_flag) begin
            lock_error_flag <= 1'b1;
         end else if (status_rd) begin
            lock_error_flag <= 1'b0;
         end
         irq <= (ready_int_en && ready_flag && irq_ok)
             || (lock_err_int_en && lock_error_flag);
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   cmd_clears_ready_a: assert property (cmd_acc |=> !ready_flag)
      else $error("ready not cleared by command write");
   done_sets_ready_a: assert property (state == ST_DONE |=> ready_flag)
      else $error("ready not set at completion");
   read_stall_a: assert property (sb_req && !sb_bus.write && busy |-> !sb_ready)
      else $error("read completed while busy");
   buf_wait_a: assert property (sb_req && sb_bus.write && !busy && wcnt == 3'h0 && !rd_pend
      |-> !sb_ready ##1 (!sb_ready)[*3] ##1 sb_ready)
      else $error("buffer write wait states wrong");
   busy_cmd_err_a: assert property (cmd_wr && busy |=> programming_error_flag)
      else $error("busy command not flagged");
   bad_key_a: assert property (go && !key_ok |=> programming_error_flag ##1 ready_flag)
      else $error("bad key not flagged");
   start_idle_a: assert property (state == ST_PEND && sb_req |=> state == ST_PEND)
      else $error("command started on busy bus");
   err_clear_a: assert property (status_rd && !ev_programming_error_flag && !ev_lock_error_flag
      |=> !programming_error_flag && !lock_error_flag)
      else $error("status read did not clear errors");
   page_prog_len_a: assert property (go && key_ok && cmd == fps_pkg::CMD_WP && !prot_hit
      |-> ##65 state == ST_DONE)
      else $error("page program length wrong");
   locked_page_a: assert property (go && key_ok && cmd == fps_pkg::CMD_WP && prot_hit
      |=> lock_error_flag && state == ST_DONE)
      else $error("locked page not refused");
   ea_block_a: assert property (go && key_ok && cmd == fps_pkg::CMD_EA && ea_blocked
      |=> lock_error_flag && nvm_cmd.op == fps_pkg::NVM_NOP)
      else $error("blocked erase-all not refused");
   buf_page_a: assert property (sb_req && sb_bus.write && wcnt == 3'h0 && !busy
      && !rd_pend && !cmd_acc
      |=> page_number_field == sb_bus.addr[fps_pkg::ADDR_W-1:fps_pkg::WIDX_W])
      else $error("page field not taken from buffer write");
   err_set_a: assert property (ev_programming_error_flag |=> programming_error_flag)
      else $error("programming error not raised");
   vclr_wait_a: assert property (state == ST_VCLR && !vol_clear_done
      |=> nvm_cmd.op == fps_pkg::NVM_NOP)
      else $error("array erased before volatile clear");
   ready_irq_a: assert property (ready_int_en && ready_flag && irq_ok |=> irq)
      else $error("ready interrupt missing");
   lock_irq_a: assert property (lock_err_int_en && lock_error_flag |=> irq)
      else $error("lock error interrupt missing");

   page_prog_c: cover property (state == ST_PROG ##1 state == ST_DONE);
   quick_chk_c: cover property (state == ST_QCHK ##1 state == ST_DONE);
   erase_all_c: cover property (state == ST_VCLR && vol_clear_done);
   busy_cmd_c: cover property (cmd_wr && busy);
   read_stall_c: cover property (sb_req && !sb_bus.write && busy);
endmodule
`default_nettype wire
